//--- dvid_pkg.sv
/*
 * Constants, mode codes and helpers for the dynamic voltage-select tracker.
 * Assumes a 100 MHz system clock; the sample and slew divider counts are derived from it here.
 */
// Overview of operation
// - The voltage-select inputs are sampled on every tick of a 3 MHz sampling strobe in every mode.
// - A changed code is accepted only after the same new value is read on three consecutive samples.
// - In direct-step modes the accepted code is loaded into the reference DAC at once in one update.
// - In slewing modes a new code that differs by more than one step is accepted.
// - In slewing modes the DAC steps 6.25 mV per step at 330 kHz toward the target and stops on equality.
// - The configured reference-table mode chooses direct update or stepped slewing.
package dvid_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_FREQ_KHZ = 100000;
    localparam int SAMPLE_FREQ_KHZ = 3000;
    localparam int SLEW_FREQ_KHZ = 330;
    // Period rounds down, so the strobe runs a hair fast rather than slow
    localparam int SAMPLE_DIV = CLK_FREQ_KHZ / SAMPLE_FREQ_KHZ;
    localparam int SLEW_DIV = CLK_FREQ_KHZ / SLEW_FREQ_KHZ;
    localparam int STABLE_READS = 3;
    localparam int STEP_UV = 6250;
    localparam int DIRECT_MIN_SPACING_NS = 2000;

    // ****************************************
    // Widths and reset values
    // ****************************************
    localparam int CODE_W = 8;
    localparam logic [CODE_W-1:0] CODE_RST = 8'h00;

    // ****************************************
    // Reference-table modes
    // ****************************************
    typedef enum logic [1:0]
    {
        MODE_DIRECT_TEN = 2'h0,
        MODE_DIRECT_ELEVEN = 2'h1,
        MODE_SLEW_FIVE = 2'h2,
        MODE_SLEW_SIX = 2'h3
    } table_mode_t;

    typedef enum logic
    {
        ST_HOLD = 1'b0,
        ST_SLEW = 1'b1
    } slew_state_t;

    function automatic logic isSlewMode(input table_mode_t m);
        isSlewMode = (m == MODE_SLEW_FIVE) || (m == MODE_SLEW_SIX);
    endfunction

endpackage

//--- vsc_if.sv
/*
 * Carrier between the code validator and the tracker core.
 * Assumes both ends share sys_clk.
 */
`timescale 1ns/1ps
interface vsc_if #(parameter int CODE_W = 8);
    logic [CODE_W-1:0] acceptedCode;
    logic acceptPulse;

    modport validator (output acceptedCode, output acceptPulse);
    modport core (input acceptedCode, input acceptPulse);
endinterface

//--- vsc_validator.sv
/*
 * Samples the voltage-select code on a 3 MHz strobe and validates changes.
 * Assumes the code input is synchronous to sys_clk.
 */
`timescale 1ns/1ps
module vsc_validator #(
    parameter int CODE_W = dvid_pkg::CODE_W,
    parameter int SAMPLE_DIV = dvid_pkg::SAMPLE_DIV
)(
    input wire logic sysClk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic [CODE_W-1:0] voltageSelectCode,
    vsc_if.validator link
);

    // ****************************************
    // Sampling strobe
    // ****************************************
    logic [7:0] divCnt_r, divCnt_nxt;
    logic [CODE_W-1:0] lastRead_r, lastRead_nxt;
    logic [CODE_W-1:0] accepted_r, accepted_nxt;
    logic [1:0] reads_r, reads_nxt;
    logic pulse_r, pulse_nxt;
    logic sampleTick;

    always_comb
    begin
        sampleTick = (divCnt_r == 8'(SAMPLE_DIV - 1));
        divCnt_nxt = sampleTick ? 8'h00 : divCnt_r + 8'h01;
        lastRead_nxt = lastRead_r;
        reads_nxt = reads_r;
        accepted_nxt = accepted_r;
        pulse_nxt = 1'b0;
        if (sampleTick)
        begin
            lastRead_nxt = voltageSelectCode;
            if (voltageSelectCode != lastRead_r)
                reads_nxt = 2'h1;
            else if (reads_r != 2'(dvid_pkg::STABLE_READS))
                reads_nxt = reads_r + 2'h1;
            // Third identical read of a value not yet in force
            if (voltageSelectCode == lastRead_r &&
                reads_r == 2'(dvid_pkg::STABLE_READS - 1) &&
                voltageSelectCode != accepted_r)
            begin
                accepted_nxt = voltageSelectCode;
                pulse_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge sysClk)
    begin
        if (rst)
        begin
            divCnt_r <= 8'h00;
            lastRead_r <= dvid_pkg::CODE_RST;
            accepted_r <= dvid_pkg::CODE_RST;
            reads_r <= 2'h0;
            pulse_r <= 1'b0;
        end
        else if (clkEn)
        begin
            divCnt_r <= divCnt_nxt;
            lastRead_r <= lastRead_nxt;
            accepted_r <= accepted_nxt;
            reads_r <= reads_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign link.acceptedCode = accepted_r;
    assign link.acceptPulse = pulse_r;

endmodule // vsc_validator

//--- dynamic_vid_reference_tracker.sv
/*
 * Reference DAC code tracker for dynamic voltage-select changes.
 * Assumes synchronous inputs and a processor that keeps direct-mode pacing.
 */
`timescale 1ns/1ps
module dynamic_vid_reference_tracker #(
    parameter int CODE_W = dvid_pkg::CODE_W,
    parameter int SAMPLE_DIV = dvid_pkg::SAMPLE_DIV,
    parameter int SLEW_DIV = dvid_pkg::SLEW_DIV
)(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic [CODE_W-1:0] voltageSelectCode,
    input wire logic [1:0] tableMode,
    output logic [CODE_W-1:0] dacCode_r,
    output logic [CODE_W-1:0] targetCode_r,
    output logic slewBusy_r,
    output logic codeAccepted_r
);

    // ****************************************
    // Validation
    // ****************************************
    vsc_if #(.CODE_W(CODE_W)) link ();

    // Direct modes rely on the processor pacing single steps
    vsc_validator #(
        .CODE_W(CODE_W),
        .SAMPLE_DIV(SAMPLE_DIV)
    ) validator (
        .sysClk(sys_clk),
        .rst(rst),
        .clkEn(clkEn),
        .voltageSelectCode(voltageSelectCode),
        .link(link.validator)
    );

    // ****************************************
    // Reference stepping
    // ****************************************
    dvid_pkg::slew_state_t state_r, state_nxt;
    logic [CODE_W-1:0] dac_nxt, target_nxt;
    logic [9:0] slewCnt_r, slewCnt_nxt;
    logic busy_nxt, accepted_nxt;
    logic slewTick, slewMode;

    always_comb
    begin
        slewMode = dvid_pkg::isSlewMode(dvid_pkg::table_mode_t'(tableMode));
        slewTick = (slewCnt_r == 10'(SLEW_DIV - 1));
        slewCnt_nxt = slewTick ? 10'h000 : slewCnt_r + 10'h001;
        state_nxt = state_r;
        dac_nxt = dacCode_r;
        target_nxt = targetCode_r;
        accepted_nxt = link.acceptPulse;
        if (link.acceptPulse)
            target_nxt = link.acceptedCode;
        unique case (state_r)
            dvid_pkg::ST_HOLD:
            begin
                if (link.acceptPulse)
                begin
                    if (!slewMode)
                        dac_nxt = link.acceptedCode;
                    else
                    begin
                        state_nxt = dvid_pkg::ST_SLEW;
                        // Stepping phase restarts so the first step is a
                        // full step period after acceptance
                        slewCnt_nxt = 10'h000;
                    end
                end
            end
            dvid_pkg::ST_SLEW:
            begin
                if (!slewMode)
                begin
                    // A switch to a direct mode mid-slew lands on the target at once
                    dac_nxt = target_nxt;
                    state_nxt = dvid_pkg::ST_HOLD;
                end
                else if (slewTick)
                begin
                    // One LSB is one 6.25 mV step
                    if (dacCode_r < target_nxt)
                        dac_nxt = dacCode_r + CODE_W'(1);
                    else if (dacCode_r > target_nxt)
                        dac_nxt = dacCode_r - CODE_W'(1);
                    if (dac_nxt == target_nxt)
                        state_nxt = dvid_pkg::ST_HOLD;
                end
            end
        endcase
        busy_nxt = (state_nxt == dvid_pkg::ST_SLEW);
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_r <= dvid_pkg::ST_HOLD;
            dacCode_r <= dvid_pkg::CODE_RST;
            targetCode_r <= dvid_pkg::CODE_RST;
            slewCnt_r <= 10'h000;
            slewBusy_r <= 1'b0;
            codeAccepted_r <= 1'b0;
        end
        else if (clkEn)
        begin
            state_r <= state_nxt;
            dacCode_r <= dac_nxt;
            targetCode_r <= target_nxt;
            slewCnt_r <= slewCnt_nxt;
            slewBusy_r <= busy_nxt;
            codeAccepted_r <= accepted_nxt;
        end
    end

endmodule // dynamic_vid_reference_tracker

//--- dvid_tracker_sva.sv
/* Port checker for the reference tracker.
   Assumes a bind from tb_top and a slew divider of 8. */
`timescale 1ns/1ps
module dvid_tracker_sva #(parameter int CODE_W = 8)(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [1:0] tableMode,
    input wire logic [CODE_W-1:0] dacCode_r,
    input wire logic [CODE_W-1:0] targetCode_r,
    input wire logic slewBusy_r,
    input wire logic codeAccepted_r
);
    // ****
    // Assertions
    // ****
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (rst);
    tgt_change_a: assert property (
        !$stable(targetCode_r) |-> codeAccepted_r)
        else $error("target moved without accept");
    accept_pulse_a: assert property (
        codeAccepted_r |-> !$stable(targetCode_r) ##1 !codeAccepted_r)
        else $error("bad accept pulse");
    direct_load_a: assert property (
        !tableMode[1] && !$past(tableMode[1])
        |-> dacCode_r == targetCode_r && !slewBusy_r)
        else $error("direct mode not loaded");
    slew_step_a: assert property (
        tableMode[1] && $past(tableMode[1]) && !$stable(dacCode_r)
        |-> (($past(dacCode_r) < $past(targetCode_r)) ?
        dacCode_r == $past(dacCode_r) + 1'b1 :
        dacCode_r == $past(dacCode_r) - 1'b1))
        else $error("bad slew step");
    // Fixed count: the bench runs the slew divider at 8
    slew_start_a: assert property (
        tableMode[1] && $rose(slewBusy_r) && dacCode_r != targetCode_r
        |-> $stable(dacCode_r) [*8] ##1 !$stable(dacCode_r))
        else $error("bad slew rate");
    slew_done_a: assert property (
        $fell(slewBusy_r) |-> dacCode_r == targetCode_r)
        else $error("slew ended off target");
    busy_mode_a: assert property (
        slewBusy_r |-> $past(tableMode[1]))
        else $error("busy in direct mode");
endmodule // dvid_tracker_sva

//--- vsc_processor_model.sv
/* Processor model driving the voltage-select code.
   Assumes it shares sys_clk with the tracker. */
`timescale 1ns/1ps
module vsc_processor_model (
    input wire logic sys_clk,
    output logic [7:0] code
);
    // ****
    // Drive
    // ****
    initial code = 8'h00;
    task automatic setCode(input logic [7:0] v);
        @(posedge sys_clk);
        code <= v;
    endtask
    // Direct modes: only one step per call, caller keeps the spacing
    task automatic stepCode(input logic up);
        setCode(up ? code + 8'h01 : code - 8'h01);
    endtask
endmodule // vsc_processor_model

//--- tb_top.sv
/* Self-checking bench for the reference tracker.
   Assumes the model and checker files compile first. */
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic rst;
    logic clkEn;
    logic [1:0] tableMode;
    logic [7:0] code;
    logic [7:0] dac;
    logic [7:0] target;
    logic busy;
    logic acc;
    logic [7:0] expCode = 8'h00;
    int errors = 0;
    int comparisons = 0;
    int n;
    always #5 sys_clk = ~sys_clk;
    vsc_processor_model src (.sys_clk(sys_clk), .code(code));
    dynamic_vid_reference_tracker #(.SAMPLE_DIV(4), .SLEW_DIV(8)) dut (
        .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
        .voltageSelectCode(code), .tableMode(tableMode), .dacCode_r(dac),
        .targetCode_r(target), .slewBusy_r(busy), .codeAccepted_r(acc));
    // ****
    // Helpers
    // ****
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic checkFlag(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Sample one ns after the edge so design updates have landed
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic waitAcc(input logic want);
        n = 0;
        do
        begin
            tick(1);
            n++;
        end
        while (acc !== 1'b1 && n < 60);
        checkFlag(acc, want);
        if (want && n >= 60)
            give_verdict();
    endtask
    task automatic waitIdle();
        n = 0;
        while (busy === 1'b1 && n < 300)
        begin
            tick(1);
            n++;
        end
        checkFlag(busy, 1'b0);
        if (n >= 300)
            give_verdict();
    endtask
    // ****
    // Scenarios
    // ****
    task automatic testDirect();
        for (int i = 0; i < 6; i++)
        begin
            @(posedge sys_clk);
            tableMode <= (i < 3) ? 2'h0 : 2'h1;
            expCode = (i % 3 == 1) ? expCode - 8'h01 : expCode + 8'h01;
            src.stepCode(i % 3 != 1);
            waitAcc(1'b1);
            check(dac, expCode);
            check(target, expCode);
            tick(200);
        end
    endtask
    task automatic testRefuse();
        src.setCode(expCode + 8'h01);
        repeat (4) @(posedge sys_clk);
        src.setCode(expCode);
        waitAcc(1'b0);
        @(posedge sys_clk);
        clkEn <= 1'b0;
        src.setCode(expCode + 8'h01);
        waitAcc(1'b0);
        @(posedge sys_clk);
        clkEn <= 1'b1;
        expCode++;
        waitAcc(1'b1);
        check(dac, expCode);
    endtask
    task automatic testSlew();
        @(posedge sys_clk);
        tableMode <= 2'h2;
        src.setCode(8'h0a);
        waitAcc(1'b1);
        waitIdle();
        check(8'(n), 8'((8'h0a - expCode) * 8));
        check(dac, 8'h0a);
        @(posedge sys_clk);
        tableMode <= 2'h3;
        src.setCode(8'h00);
        waitAcc(1'b1);
        tick(20);
        src.setCode(8'h05);
        waitAcc(1'b1);
        waitIdle();
        check(dac, 8'h05);
        src.setCode(8'h30);
        waitAcc(1'b1);
        tick(12);
        @(posedge sys_clk);
        tableMode <= 2'h0;
        tick(2);
        check(dac, 8'h30);
        checkFlag(busy, 1'b0);
    endtask
    initial
    begin
        rst = 1'b1;
        clkEn = 1'b1;
        tableMode = 2'h0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        testDirect();
        testRefuse();
        testSlew();
        give_verdict();
    end
endmodule // tb_top
bind dynamic_vid_reference_tracker dvid_tracker_sva sva (
    .sys_clk(sys_clk), .rst(rst), .tableMode(tableMode),
    .dacCode_r(dacCode_r), .targetCode_r(targetCode_r),
    .slewBusy_r(slewBusy_r), .codeAccepted_r(codeAccepted_r));
